// File: hw/switch_forwarding_policy.sv
/*
  Forwarding policy of a multiport switch: spanning tree gating, host trailer,
  trapping, mirroring, egress scheduling and rate limiting, with AHB-Lite registers.
  Assumes descriptors from the lookup stage arrive as one-cycle requests.
*/
// Local design decisions: the AHB-Lite interface to the registers and the address map.
// Operation
// - Discarding port forwards no user frames and learns nothing.
// - Override static hits from a discarding port still go to host.
// - Ports with learning disabled can have their table entries flushed.
// - Learning state learns addresses, forwards only host traffic.
// - Forwarding state forwards everything and learns.
// - Entry selects one of eight tree instances; per-port state per instance.
// - Frames to host carry two trailer bytes naming the ingress port.
// - Host trailer names egress port and queue; trailer is stripped.
// - Trailer sits before the check sequence, which covers it.
// - IPv4 group-management frames go only to the host port.
// - Known multicast goes only to listed ports, not flooded.
// - IPv6 listener discovery frames go only to the host port.
// - Frames received on rx-mirrored ports copied to sniffer; bad optional.
// - Frames sent on tx-mirrored ports copied to sniffer.
// - Rx-mirrored to tx-mirrored frames copied to sniffer.
// - Strict priority: highest ready queue wins, queue 3 top.
// - Weighted round robin favours high queues, never starves low.
// - Rate above link speed means unlimited.
// - Rate counts frame bytes, optional gap, per priority per port.
// - Ingress limiting counts chosen classes, drops above limit.
// - Egress leaky bucket stretches gaps per queue.
`timescale 1ns/1ps
`default_nettype none
module switch_forwarding_policy
  import fwd_pkg::*;
#(
  parameter int PORTS = NPORTS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Frame descriptor from lookup.
  input wire logic req_valid,
  input wire logic [PW-1:0] req_src,
  input wire logic [PORTS-1:0] req_dst,
  input wire logic [IW-1:0] req_inst,
  input wire logic req_ovr,
  input wire logic req_mcast,
  input wire logic req_bcast,
  input wire logic req_hit,
  input wire logic req_ip,
  input wire logic [3:0] req_ipver,
  input wire logic [7:0] req_ipproto,
  input wire logic req_mld,
  input wire logic req_err,
  input wire logic [13:0] req_len,
  input wire logic [QW-1:0] req_prio,
  input wire logic [PORTS-1:0] req_tag_dst,
  input wire logic [QW-1:0] req_tag_q,
  // Forwarding decision.
  output logic fwd_valid,
  output logic [PORTS-1:0] fwd_mask,
  output logic [QW-1:0] fwd_queue,
  output logic fwd_learn,
  output logic fwd_drop,
  output logic fwd_tag_add,
  output logic [TAG_W-1:0] fwd_tag,
  output logic fwd_tag_strip,
  // Egress scheduling.
  input wire logic sch_req,
  input wire logic [PW-1:0] sch_port,
  input wire logic [NQ-1:0] sch_ready,
  input wire logic tx_done,
  input wire logic [PW-1:0] tx_port,
  input wire logic [QW-1:0] tx_queue,
  input wire logic [13:0] tx_len,
  output logic grant_done,
  output logic grant_hit,
  output logic [QW-1:0] grant_queue,
  // Table flush request.
  output logic [PORTS-1:0] flush_mask
);
  localparam int SW = NINST * ST_W;
  localparam int CH = PORTS * NQ;
  localparam logic [ADDR_W-1:0] STP_END = ADDR_W'(int'(OFF_STP) + (PORTS << REG_SHIFT));
  localparam logic [LW-1:0] ING_LIMIT = LW'(ING_BURST_BYTES * UNITS_PER_BYTE);
  localparam logic [LW-1:0] EG_LIMIT = '0;

  if (PORTS < 2 || PORTS > (1 << PW) || NQ != (1 << QW))
  begin : g_chk
    $error("switch_forwarding_policy: PORTS out of range");
  end

  function automatic logic [PORTS-1:0] one_hot(input logic [PW-1:0] p);
    return PORTS'(1) << p;
  endfunction

  function automatic logic [ST_W-1:0] st_of(input logic [PORTS*SW-1:0] all, input logic [PW-1:0] p,
                                            input logic [IW-1:0] i);
    return all[int'(p)*SW + int'(i)*ST_W +: ST_W];
  endfunction

  function automatic logic is_fwd(input logic [ST_W-1:0] s);
    return s[ST_TX] && s[ST_RX] && !s[ST_LD];
  endfunction

  function automatic logic rate_unl(input logic [7:0] r, input logic spd100);
    return r == 8'h00 || r > (spd100 ? RATE_100 : RATE_10);
  endfunction

  function automatic logic [LW-1:0] frame_units(input logic [13:0] len, input logic gap);
    return LW'(({2'b00, len} + (gap ? IFG_PRE_BYTES : 16'h0000)) * UNITS_PER_BYTE);
  endfunction

  function automatic logic [QW:0] pick_hi(input logic [NQ-1:0] v);
    logic [QW:0] r;
    r = '0;
    for (int q = 0; q < NQ; q++)
      if (v[q])
        r = {1'b1, QW'(q)};
    return r;
  endfunction

  // Register file and bus.
  logic [31:0] ctrl;
  logic [31:0] rate;
  logic [PORTS-1:0] rx_sniff;
  logic [PORTS-1:0] tx_sniff;
  logic [15:0] drop_cnt;
  logic [ADDR_W-1:0] a_addr;
  logic a_ok;
  logic a_wr;
  bus_state_t bs;
  logic [PORTS*SW-1:0] stp_all;

  wire acc = hsel && htrans[1] && hready;
  wire addr_ok = haddr[31:ADDR_W] == '0 && haddr[1:0] == 2'b00;
  wire wr_ctrl = a_wr && a_ok && a_addr == OFF_CTRL;
  wire wr_mir = a_wr && a_ok && a_addr == OFF_MIRROR;
  wire wr_flush = a_wr && a_ok && a_addr == OFF_FLUSH;
  wire wr_rate = a_wr && a_ok && a_addr == OFF_RATE;
  wire stp_hit = a_ok && a_addr >= OFF_STP && a_addr < STP_END;
  wire [PW-1:0] stp_idx = PW'((a_addr - OFF_STP) >> REG_SHIFT);
  wire [SW-1:0] stp_rword = stp_all[int'(stp_idx)*SW +: SW];
  wire [31:0] rd_mux = !a_ok ? 32'h0000_0000
                     : a_addr == OFF_CTRL ? ctrl
                     : a_addr == OFF_MIRROR ? 32'({tx_sniff, {(MIR_TX_LSB - PORTS){1'b0}}, rx_sniff})
                     : a_addr == OFF_RATE ? rate
                     : a_addr == OFF_STATUS ? 32'(drop_cnt)
                     : stp_hit ? 32'(stp_rword)
                     : 32'h0000_0000;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      a_addr <= '0;
      a_ok <= 1'b0;
      a_wr <= 1'b0;
      bs <= BS_IDLE;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      a_wr <= acc && hwrite;
      if (acc)
      begin
        a_addr <= haddr[ADDR_W-1:0];
        a_ok <= addr_ok;
      end
      case (bs)
        BS_IDLE:
        begin
          if (acc && !hwrite)
          begin
            bs <= BS_RD;
            hreadyout <= 1'b0;
          end
        end
        BS_RD:
        begin
          hrdata <= rd_mux;
          hreadyout <= 1'b1;
          bs <= BS_IDLE;
        end
        default:
        begin
          bs <= BS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl <= CTRL_RESET;
      rate <= 32'h0000_0000;
      rx_sniff <= '0;
      tx_sniff <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= hwdata & CTRL_MASK;
      if (wr_rate)
        rate <= hwdata & RATE_MASK;
      if (wr_mir)
      begin
        rx_sniff <= hwdata[PORTS-1:0];
        tx_sniff <= hwdata[MIR_TX_LSB +: PORTS];
      end
    end
  end

  stp_state_mem #(.DEPTH(PORTS), .AW(PW), .W(SW), .RST_WORD({NINST{ST_FWD_CODE}})) u_stp (
    .clk(clk),
    .nrst(nrst),
    .we(a_wr && stp_hit),
    .waddr(stp_idx),
    .wdata(hwdata[SW-1:0]),
    .q_all(stp_all)
  );

  // Configuration fields.
  wire [PW-1:0] host_port = ctrl[CTRL_HOST_LSB +: PW];
  wire [PW-1:0] sniffer = ctrl[CTRL_SNIF_LSB +: PW];
  wire gap_on = ctrl[CTRL_IFG];
  wire spd100 = ctrl[CTRL_SPD100];
  wire wrr_on = ctrl[CTRL_WRR];
  wire four_q = ctrl[CTRL_FOURQ];
  wire rate_cls_t cls = rate_cls_t'(ctrl[CTRL_CLS_LSB +: 2]);
  wire [7:0] rate_in = rate[7:0];
  wire [7:0] rate_eg = rate[RATE_EG_LSB +: 8];
  // A single trailer port is assumed; the host port field holds exactly one index.
  wire [PORTS-1:0] host_bit = one_hot(host_port);
  wire [PORTS-1:0] sniff_bit = one_hot(sniffer);
  wire [PORTS-1:0] src_bit = one_hot(req_src);

  // Per-port states of the instance that the entry selects, and of the instance that the flush write names.
  wire [ST_W-1:0] src_st = st_of(stp_all, req_src, req_inst);
  wire src_fwd = is_fwd(src_st);
  wire src_disc = src_st[ST_LD];
  logic [PORTS-1:0] dst_fwd;
  logic [PORTS-1:0] dst_host_ok;
  logic [PORTS-1:0] flush_ok;
  for (genvar p = 0; p < PORTS; p++)
  begin : g_port
    wire [ST_W-1:0] ds = st_of(stp_all, PW'(p), req_inst);
    wire [ST_W-1:0] fs = st_of(stp_all, PW'(p), hwdata[FLUSH_INST_LSB +: IW]);
    assign dst_fwd[p] = is_fwd(ds);
    assign dst_host_ok[p] = !ds[ST_LD];
    assign flush_ok[p] = fs[ST_LD];
  end

  // Ingress rate limiting.
  logic [CH-1:0] ing_over;
  logic [CH-1:0] eg_over;
  wire from_host = req_src == host_port;
  wire cls_hit = cls == CLS_ALL ? 1'b1
               : cls == CLS_MCAST ? req_mcast
               : cls == CLS_BCAST ? req_bcast
               : !req_mcast && !req_bcast && !req_hit;
  wire ing_unl = rate_unl(rate_in, spd100);
  wire [$clog2(CH)-1:0] ing_ch = ($clog2(CH))'({req_src, req_prio});
  wire ing_drop = !from_host && !req_err && cls_hit && ing_over[ing_ch];
  wire ing_add = req_valid && !from_host && !req_err && cls_hit && !ing_drop;

  rate_bucket #(.CH(CH), .LW(LW)) u_ing (
    .clk(clk),
    .nrst(nrst),
    .add_en(ing_add),
    .add_ch(ing_ch),
    .add_units(frame_units(req_len, gap_on)),
    .drain(rate_in),
    .limit(ING_LIMIT),
    .unlimited(ing_unl),
    .over(ing_over)
  );

  // Forwarding decision.
  wire trap = (req_ip && req_ipver == IPV4_VER && req_ipproto == IGMP_PROTO) || req_mld;
  wire [PORTS-1:0] base = (req_mcast && !req_hit) || req_bcast ? {PORTS{1'b1}} : req_dst;
  wire [PORTS-1:0] norm = base & ~src_bit & (dst_fwd | host_bit);
  wire rx_m = rx_sniff[req_src];
  wire tx_m = |(norm & tx_sniff);
  wire [PORTS-1:0] next_mask = from_host ? (req_tag_dst & dst_host_ok & ~host_bit)
                             : req_err ? ((ctrl[CTRL_BAD] && rx_m && !src_disc) ? sniff_bit : '0)
                             : ing_drop ? '0
                             : req_ovr ? host_bit
                             : trap ? (src_disc ? '0 : host_bit)
                             : src_fwd ? (norm | ((rx_m || tx_m) ? sniff_bit : '0))
                             : src_disc ? '0
                             : (req_dst & host_bit);
  wire next_learn = !src_disc && !req_err && !from_host && !ing_drop;
  wire next_tag_add = !from_host && |(next_mask & host_bit);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fwd_valid <= 1'b0;
      fwd_mask <= '0;
      fwd_queue <= '0;
      fwd_learn <= 1'b0;
      fwd_drop <= 1'b0;
      fwd_tag_add <= 1'b0;
      fwd_tag <= '0;
      fwd_tag_strip <= 1'b0;
      drop_cnt <= 16'h0000;
      flush_mask <= '0;
    end
    else
    begin
      fwd_valid <= req_valid;
      fwd_mask <= req_valid ? next_mask : '0;
      fwd_queue <= from_host ? req_tag_q : req_prio;
      fwd_learn <= req_valid && next_learn;
      fwd_drop <= req_valid && next_mask == '0;
      // Inserted ahead of the check sequence by the frame path, which recomputes it.
      fwd_tag_add <= req_valid && next_tag_add;
      fwd_tag <= TAG_W'(src_bit);
      fwd_tag_strip <= req_valid && from_host;
      if (req_valid && ing_drop)
        drop_cnt <= drop_cnt + 16'h0001;
      flush_mask <= wr_flush ? (hwdata[PORTS-1:0] & flush_ok) : '0;
    end
  end

  // Egress scheduling and shaping.
  logic [WW-1:0] credit [NQ];
  logic [NQ-1:0] elig;
  logic [NQ-1:0] cred_nz;
  for (genvar q = 0; q < NQ; q++)
  begin : g_q
    assign elig[q] = sch_ready[q] && !eg_over[($clog2(CH))'({sch_port, QW'(q)})] && (four_q || q < NQ_TWO);
    assign cred_nz[q] = credit[q] != '0;
  end
  wire [NQ-1:0] cand = elig & cred_nz;
  wire reload = cand == '0;
  wire [QW:0] pick = pick_hi(wrr_on ? (reload ? elig : cand) : elig);
  wire eg_unl = rate_unl(rate_eg, spd100);

  for (genvar q = 0; q < NQ; q++)
  begin : g_cred
    wire [WW-1:0] cbase = reload ? WW'(WRR_BASE << q) : credit[q];
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        credit[q] <= '0;
      else if (sch_req && pick[QW] && wrr_on)
        credit[q] <= cbase - WW'(pick[QW-1:0] == QW'(q));
    end
  end

  rate_bucket #(.CH(CH), .LW(LW)) u_eg (
    .clk(clk),
    .nrst(nrst),
    .add_en(tx_done),
    .add_ch(($clog2(CH))'({tx_port, tx_queue})),
    .add_units(frame_units(tx_len, gap_on)),
    .drain(rate_eg),
    .limit(EG_LIMIT),
    .unlimited(eg_unl),
    .over(eg_over)
  );

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      grant_done <= 1'b0;
      grant_hit <= 1'b0;
      grant_queue <= '0;
    end
    else
    begin
      grant_done <= sch_req;
      grant_hit <= sch_req && pick[QW];
      grant_queue <= pick[QW-1:0];
    end
  end

  property p_disc_block;
    @(posedge clk) disable iff (!nrst)
      req_valid && src_disc && !req_ovr && !from_host |=> fwd_mask == '0 && !fwd_learn;
  endproperty
  a_disc_block: assert property (p_disc_block) else $error("discarding port forwarded or learned");

  property p_override;
    @(posedge clk) disable iff (!nrst)
      req_valid && req_ovr && !from_host && !req_err && !ing_drop |=> fwd_mask == $past(host_bit) && fwd_tag_add;
  endproperty
  a_override: assert property (p_override) else $error("override hit not sent to host");

  property p_learning;
    @(posedge clk) disable iff (!nrst)
      req_valid && !src_disc && !src_fwd && !from_host && !req_err && !ing_drop
      |=> (fwd_mask & ~$past(host_bit)) == '0 && fwd_learn;
  endproperty
  a_learning: assert property (p_learning) else $error("learning state forwarded user frame");

  property p_tag;
    @(posedge clk) disable iff (!nrst)
      fwd_tag_add |-> fwd_tag == TAG_W'(one_hot($past(req_src))) && !fwd_tag_strip;
  endproperty
  a_tag: assert property (p_tag) else $error("trailer does not name ingress port");

  property p_host_in;
    @(posedge clk) disable iff (!nrst)
      req_valid && from_host |=> fwd_tag_strip && fwd_queue == $past(req_tag_q) && !fwd_tag_add;
  endproperty
  a_host_in: assert property (p_host_in) else $error("host trailer not honoured");

  property p_trap;
    @(posedge clk) disable iff (!nrst)
      req_valid && trap && !req_ovr && !req_err && !ing_drop && !from_host && !src_disc
      |=> fwd_mask == $past(host_bit);
  endproperty
  a_trap: assert property (p_trap) else $error("management frame not trapped to host");

  property p_txmir;
    @(posedge clk) disable iff (!nrst)
      req_valid && src_fwd && tx_m && !from_host && !req_err && !ing_drop && !req_ovr && !trap
      |=> |(fwd_mask & $past(sniff_bit));
  endproperty
  a_txmir: assert property (p_txmir) else $error("transmit mirror copy missing");

  property p_strict;
    @(posedge clk) disable iff (!nrst)
      sch_req && !wrr_on && elig[NQ-1] |=> grant_hit && grant_queue == QW'(NQ - 1);
  endproperty
  a_strict: assert property (p_strict) else $error("top queue lost strict arbitration");

  property p_unl;
    @(posedge clk) disable iff (!nrst)
      $past(ing_unl) && $past(eg_unl) |-> ing_over == '0 && eg_over == '0;
  endproperty
  a_unl: assert property (p_unl) else $error("rate above link speed still limited");
endmodule
`default_nettype wire

// File: hw/fwd_pkg.sv
/*
  Constants, register map and types of the switch forwarding-policy block.
  Assumes a 200 MHz core clock and a 32-bit AHB-Lite register port.
*/
package fwd_pkg;
  localparam int NPORTS = 5;
  localparam int PW = 3;
  localparam int NINST = 8;
  localparam int IW = 3;
  localparam int NQ = 4;
  localparam int QW = 2;
  localparam int NQ_TWO = 2;
  localparam int WW = 4;
  localparam int TAG_W = 16;
  localparam int LW = 28;
  localparam int ADDR_W = 8;
  localparam int REG_SHIFT = 2;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_MHZ = 1000 / CLK_PERIOD_NS;
  // Bucket units: one byte is 8 bits times clock cycles per microsecond.
  localparam int UNITS_PER_BYTE = 8 * CLK_MHZ;
  localparam int ING_BURST_BYTES = 2048;
  localparam logic [15:0] IFG_PRE_BYTES = 16'h0014;
  localparam logic [7:0] RATE_10 = 8'h0a;
  localparam logic [7:0] RATE_100 = 8'h64;
  localparam logic [3:0] IPV4_VER = 4'h4;
  localparam logic [7:0] IGMP_PROTO = 8'h02;
  localparam logic [WW-1:0] WRR_BASE = 4'h1;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MIRROR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FLUSH = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RATE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STP = 8'h20;

  localparam int CTRL_HOST_LSB = 0;
  localparam int CTRL_SNIF_LSB = 4;
  localparam int CTRL_BAD = 8;
  localparam int CTRL_WRR = 9;
  localparam int CTRL_IFG = 10;
  localparam int CTRL_SPD100 = 11;
  localparam int CTRL_CLS_LSB = 12;
  localparam int CTRL_FOURQ = 14;
  localparam logic [31:0] CTRL_MASK = 32'h0000_7f77;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int MIR_TX_LSB = 8;
  localparam int FLUSH_INST_LSB = 8;
  localparam int RATE_EG_LSB = 16;
  localparam logic [31:0] RATE_MASK = 32'h00ff_00ff;

  localparam int ST_W = 3;
  localparam int ST_LD = 0;
  localparam int ST_RX = 1;
  localparam int ST_TX = 2;
  localparam logic [ST_W-1:0] ST_FWD_CODE = 3'h6;

  typedef enum logic [1:0] {CLS_ALL = 2'b00, CLS_MCAST = 2'b01, CLS_BCAST = 2'b10, CLS_FLOOD = 2'b11} rate_cls_t;
  typedef enum logic {BS_IDLE = 1'b0, BS_RD = 1'b1} bus_state_t;
endpackage

// File: hw/stp_state_mem.sv
/*
  Per-port spanning tree state words, one word per port.
  Assumes a single writer; all words are read from their storage registers.
*/
`timescale 1ns/1ps
`default_nettype none
module stp_state_mem #(
  parameter int DEPTH = 5,
  parameter int AW = 3,
  parameter int W = 24,
  parameter logic [W-1:0] RST_WORD = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Write port.
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // All words.
  output logic [DEPTH*W-1:0] q_all
);
  if (DEPTH < 1 || DEPTH > (1 << AW))
  begin : g_chk
    $error("stp_state_mem: DEPTH does not fit AW");
  end

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_word
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
        q_all[i*W +: W] <= RST_WORD;
      else if (we && waddr == AW'(i))
        q_all[i*W +: W] <= wdata;
    end
  end
endmodule
`default_nettype wire

// File: hw/rate_bucket.sv
/*
  Leaky bucket levels, one per channel, drained each cycle by the rate figure.
  Assumes the caller adds a frame's units only when the frame is accepted.
*/
`timescale 1ns/1ps
`default_nettype none
module rate_bucket #(
  parameter int CH = 20,
  parameter int LW = 28
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Frame accounting.
  input wire logic add_en,
  input wire logic [$clog2(CH)-1:0] add_ch,
  input wire logic [LW-1:0] add_units,
  // Rate settings.
  input wire logic [7:0] drain,
  input wire logic [LW-1:0] limit,
  input wire logic unlimited,
  // Level above limit, per channel.
  output logic [CH-1:0] over
);
  if (CH < 2)
  begin : g_chk
    $error("rate_bucket: CH must be at least 2");
  end

  logic [LW-1:0] lvl [CH];

  for (genvar c = 0; c < CH; c++)
  begin : g_ch
    wire [LW-1:0] dec = (lvl[c] > LW'(drain)) ? lvl[c] - LW'(drain) : '0;
    wire [LW-1:0] inc = (add_en && add_ch == ($clog2(CH))'(c)) ? add_units : '0;
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        lvl[c] <= '0;
        over[c] <= 1'b0;
      end
      else
      begin
        lvl[c] <= unlimited ? '0 : dec + inc;
        over[c] <= !unlimited && (lvl[c] > limit);
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/host_trailer_model.sv
/*
  Host processor on the trailer port: supplies the trailer contents that it
  appends to its own frames. Assumes the bench raises en one cycle ahead.
*/
`timescale 1ns/1ps
`default_nettype none
module host_trailer_model
  import fwd_pkg::*;
#(
  parameter int PORTS = NPORTS
) (
  // Clock and control.
  input wire logic clk,
  input wire logic en,
  // Trailer request.
  input wire logic [PORTS-1:0] dst,
  input wire logic [QW-1:0] q,
  // Trailer contents.
  output logic [PORTS-1:0] tag_dst = '0,
  output logic [QW-1:0] tag_q = '0
);
  // Outside its own frames the host lets the trailer lines wander.
  always_ff @(posedge clk)
  begin
    if (en)
    begin
      tag_dst <= dst;
      tag_q <= q;
    end
    else
    begin
      tag_dst <= ~tag_dst;
      tag_q <= ~tag_q;
    end
  end
endmodule
`default_nettype wire

// File: verif/switch_forwarding_policy_bench.sv
/*
  Self-checking bench of the forwarding policy block.
  Assumes the design and host model above; AHB-Lite single word transfers.
*/
`timescale 1ns/1ps
`default_nettype none
module switch_forwarding_policy_bench;
  import fwd_pkg::*;
  logic clk = 0;
  logic nrst = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic [31:0] rv;
  logic hreadyout;
  logic req_valid = 0;
  logic req_ovr = 0;
  logic req_ip = 0;
  logic req_mld = 0;
  logic [3:0] req_ipver = 0;
  logic [7:0] req_ipproto = 0;
  logic [2:0] req_src = 0;
  logic [2:0] req_inst = 0;
  logic [2:0] sch_port = 0;
  logic [4:0] req_dst = 0;
  logic [4:0] host_dst = 0;
  logic [1:0] host_q = 0;
  logic [4:0] tag_dst;
  logic [4:0] fwd_mask;
  logic [4:0] flush_mask;
  logic [1:0] tag_q;
  logic [1:0] prio = 0;
  logic [1:0] fwd_queue;
  logic [1:0] grant_queue;
  logic [1:0] g;
  logic [13:0] len = 14'h0040;
  logic [3:0] sch_ready = 0;
  logic [15:0] fwd_tag;
  logic host_en = 0;
  logic sch_req = 0;
  logic tx_done = 0;
  logic fwd_valid, fwd_learn, fwd_drop, fwd_tag_add, fwd_tag_strip, grant_done, grant_hit;
  int err_total = 0;
  int cmp_count = 0;
  int n0 = 0;
  int n3 = 0;
  always #2.5 clk = ~clk;
  switch_forwarding_policy dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .req_valid(req_valid), .req_src(req_src), .req_dst(req_dst),
    .req_inst(req_inst), .req_ovr(req_ovr), .req_mcast(1'b0), .req_bcast(1'b0), .req_hit(1'b1),
    .req_ip(req_ip), .req_ipver(req_ipver), .req_ipproto(req_ipproto), .req_mld(req_mld),
    .req_err(1'b0), .req_len(len), .req_prio(prio), .req_tag_dst(tag_dst), .req_tag_q(tag_q),
    .fwd_valid(fwd_valid), .fwd_mask(fwd_mask), .fwd_queue(fwd_queue), .fwd_learn(fwd_learn),
    .fwd_drop(fwd_drop), .fwd_tag_add(fwd_tag_add), .fwd_tag(fwd_tag), .fwd_tag_strip(fwd_tag_strip),
    .sch_req(sch_req), .sch_port(sch_port), .sch_ready(sch_ready), .tx_done(tx_done),
    .tx_port(sch_port), .tx_queue(prio), .tx_len(len), .grant_done(grant_done),
    .grant_hit(grant_hit), .grant_queue(grant_queue), .flush_mask(flush_mask));
  host_trailer_model host (.clk(clk), .en(host_en), .dst(host_dst), .q(host_q), .tag_dst(tag_dst),
    .tag_q(tag_q));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rv = hrdata;
  endtask
  task automatic desc(input logic [2:0] s, input logic [4:0] d, input logic [2:0] i, input logic o, input int k);
    req_valid <= 1;
    req_src <= s;
    req_dst <= d;
    req_inst <= i;
    req_ovr <= o;
    req_ip <= (k == 1);
    req_ipver <= IPV4_VER;
    req_ipproto <= (k == 1) ? IGMP_PROTO : 8'h06;
    req_mld <= (k == 2);
    @(posedge clk);
    req_valid <= 0;
    #1;
  endtask
  task automatic fchk(input logic [4:0] m, input logic l, input logic d, input logic t);
    chk("valid", 1, fwd_valid);
    chk("mask", m, fwd_mask);
    chk("learn", l, fwd_learn);
    chk("drop", d, fwd_drop);
    chk("tag_add", t, fwd_tag_add);
  endtask
  task automatic sch(input logic [3:0] r, input logic h);
    sch_req <= 1;
    sch_ready <= r;
    @(posedge clk);
    sch_req <= 0;
    #1;
    chk("grant_done", 1, grant_done);
    chk("grant_hit", h, grant_hit);
    g = grant_queue;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #100us;
    err_total++;
    print_verdict();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    bus(0, OFF_CTRL, 0);
    chk("ctrl", CTRL_RESET, rv);
    bus(0, OFF_STP, 0);
    chk("stp", 32'h00db_6db6, rv);
    bus(0, 32'h0000_0100, 0);
    chk("unmapped", 0, rv);
    bus(1, OFF_CTRL, 32'h0000_0040);
    desc(1, 5'b00100, 0, 0, 0);
    fchk(5'b00100, 1, 0, 0);
    bus(1, OFF_MIRROR, 32'h0000_0002);
    desc(1, 5'b00100, 0, 0, 0);
    fchk(5'b10100, 1, 0, 0);
    bus(1, OFF_MIRROR, 32'h0000_0800);
    desc(2, 5'b01000, 0, 0, 0);
    fchk(5'b11000, 1, 0, 0);
    bus(1, OFF_MIRROR, 32'h0000_0402);
    desc(1, 5'b00100, 0, 0, 0);
    fchk(5'b10100, 1, 0, 0);
    bus(1, OFF_MIRROR, 0);
    desc(1, 5'b00100, 0, 0, 1);
    fchk(5'b00001, 1, 0, 1);
    chk("tag", 16'h0002, fwd_tag);
    desc(1, 5'b00100, 0, 0, 2);
    fchk(5'b00001, 1, 0, 1);
    host_en <= 1;
    host_dst <= 5'b00100;
    host_q <= 2'b10;
    @(posedge clk);
    desc(0, 5'b00010, 0, 0, 0);
    fchk(5'b00100, 0, 0, 0);
    chk("strip", 1, fwd_tag_strip);
    chk("host_queue", 2, fwd_queue);
    host_en <= 0;
    bus(1, OFF_STP + 4, 32'h00db_6db1);
    desc(1, 5'b00100, 0, 0, 0);
    fchk(5'b00000, 0, 1, 0);
    desc(1, 5'b00100, 0, 1, 0);
    fchk(5'b00001, 0, 0, 1);
    desc(1, 5'b00100, 1, 0, 0);
    fchk(5'b00100, 1, 0, 0);
    bus(1, OFF_FLUSH, 32'h0000_0002);
    #1;
    chk("flush", 5'b00010, flush_mask);
    bus(1, OFF_STP + 4, 32'h00db_6db0);
    desc(1, 5'b00101, 0, 0, 0);
    fchk(5'b00001, 1, 0, 1);
    sch(4'b1111, 1);
    chk("queue", 1, g);
    bus(1, OFF_CTRL, 32'h0000_4040);
    sch(4'b1111, 1);
    chk("queue", 3, g);
    sch(4'b0110, 1);
    chk("queue", 2, g);
    bus(1, OFF_RATE, 32'h0001_0000);
    prio <= 2'h3;
    tx_done <= 1;
    @(posedge clk);
    tx_done <= 0;
    @(posedge clk);
    sch(4'b1000, 0);
    bus(1, OFF_RATE, 32'h000b_0000);
    @(posedge clk);
    sch(4'b1000, 1);
    bus(1, OFF_CTRL, 32'h0000_4240);
    repeat (30)
    begin
      sch(4'b1111, 1);
      n0 += (g == 0);
      n3 += (g == 3);
    end
    chk("wrr_low", 1, n0 > 0);
    chk("wrr_high", 1, n3 > n0);
    bus(1, OFF_RATE, 32'h0000_0001);
    len <= 14'h3fff;
    desc(2, 5'b01000, 0, 0, 0);
    fchk(5'b01000, 1, 0, 0);
    desc(2, 5'b01000, 0, 0, 0);
    desc(2, 5'b01000, 0, 0, 0);
    fchk(5'b00000, 0, 1, 0);
    bus(0, OFF_STATUS, 0);
    chk("drop_count", 1, rv);
    print_verdict();
  end
endmodule
`default_nettype wire
